// ===== elac_control.sv
/*
  Loopback routing, automatic alarms, transmit clock selection and monitor control
  for one E1 channel, with its two control registers on the parallel port.
  Assumes all inputs, including the sampled clock levels, are synchronous to clock_in.
*/
`timescale 1ns/100ps
module elac_control #(
  parameter int UPDATE_SLOW_CYC = elac_pkg::UPDATE_SLOW_CYC,
  parameter int UPDATE_FAST_CYC = elac_pkg::UPDATE_FAST_CYC,
  parameter int MF_SEARCH_CYC = elac_pkg::MF_SEARCH_CYC,
  parameter int MF_GIVEUP_CYC = elac_pkg::MF_GIVEUP_CYC
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic [7:0] host_addr_in,
  input wire logic host_wr_in,
  input wire logic host_rd_in,
  input wire logic [7:0] host_wdata_in,
  output logic [7:0] host_rdata_out,
  input wire logic framer_loop_enable_in,
  input wire logic crc4_enable_in,
  input wire elac_pkg::elac_bit_t tx_fmt_in,
  input wire elac_pkg::elac_bit_t line_in,
  input wire logic mclk_tick_in,
  input wire logic tx_clock_input_in,
  input wire logic rx_clock_in,
  input wire logic rx_framer_serial_in,
  input wire logic frame_sync_lost_in,
  input wire logic ais_received_in,
  input wire logic crc4_mf_sync_in,
  input wire logic bipolar_violation_in,
  input wire logic code_violation_in,
  input wire logic [4:0] tx_fmt_channel_in,
  input wire logic [7:0] tx_fmt_byte_in,
  input wire logic tx_fmt_byte_valid_in,
  output elac_pkg::elac_bit_t line_out,
  output elac_pkg::elac_bit_t rx_framer_out,
  output logic rx_clock_out,
  output logic tx_fmt_clock_out,
  output logic tx_clock_lost_out,
  output logic rx_serial_data_out,
  output logic rx_carrier_loss_out,
  output logic tx_ais_force_out,
  output logic remote_alarm_indication_out,
  output logic counter_update_out,
  output logic violation_count_out,
  output logic [7:0] tx_channel_monitor_out
);

  elac_pkg::elac_ctl2_t ctl2_r;
  elac_pkg::elac_ctl3_t ctl3_r;
  logic [7:0] rdata_r;
  elac_pkg::elac_bit_t line_out_r;
  elac_pkg::elac_bit_t line_out_nxt;
  elac_pkg::elac_bit_t rx_framer_r;
  elac_pkg::elac_bit_t rx_framer_nxt;
  logic rx_clock_r;
  logic tx_fmt_clock_r;
  logic tx_clock_prev_r;
  logic [7:0] tx_idle_r;
  logic tx_clock_lost_r;
  logic rx_serial_r;
  logic [11:0] zero_run;
  logic carrier_loss;
  logic ais_force_r;
  logic remote_alarm_r;
  logic [31:0] mf_wait_r;
  logic mf_late;
  logic mf_giveup;
  logic rx_cond;
  logic [31:0] update_cnt_r;
  logic [31:0] update_last;
  logic update_r;
  logic violation_r;
  logic [7:0] monitor_r;

  // parallel port writes
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctl2_r <= elac_pkg::LINE_ALARM_CLOCK_CONTROL_RESET;
      ctl3_r <= elac_pkg::LOOPBACK_MONITOR_CONTROL_RESET;
    end else if (host_wr_in) begin
      if (host_addr_in == elac_pkg::LINE_ALARM_CLOCK_CONTROL_ADDR) begin
        ctl2_r <= host_wdata_in;
      end else if (host_addr_in == elac_pkg::LOOPBACK_MONITOR_CONTROL_ADDR) begin
        ctl3_r <= host_wdata_in;
      end
    end
  end

  // registered read; unmapped addresses read as zero
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_r <= elac_pkg::UNMAPPED_READ_VALUE;
    end else if (host_rd_in) begin
      if (host_addr_in == elac_pkg::LINE_ALARM_CLOCK_CONTROL_ADDR) begin
        rdata_r <= ctl2_r;
      end else if (host_addr_in == elac_pkg::LOOPBACK_MONITOR_CONTROL_ADDR) begin
        rdata_r <= ctl3_r;
      end else begin
        rdata_r <= elac_pkg::UNMAPPED_READ_VALUE;
      end
    end
  end

  // line output selection
  always_comb begin
    line_out_nxt = '{data: tx_fmt_in.data | ais_force_r, en: tx_fmt_in.en};
    if (ctl3_r.line_all_ones_force) begin
      line_out_nxt = '{data: 1'b1, en: mclk_tick_in};
    end else if (ctl3_r.remote_loop_enable) begin
      line_out_nxt = line_in;
    end
  end

  // line output unaffected by framer loop
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      line_out_r <= '{data: 1'b0, en: 1'b0};
    end else begin
      line_out_r <= line_out_nxt;
    end
  end

  // receive framer feed; framer loop outranks local loop
  always_comb begin
    rx_framer_nxt = line_in;
    if (framer_loop_enable_in) begin
      rx_framer_nxt = tx_fmt_in;
    end else if (ctl3_r.local_loop_enable) begin
      rx_framer_nxt = line_out_r;
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rx_framer_r <= '{data: 1'b0, en: 1'b0};
    end else begin
      rx_framer_r <= rx_framer_nxt;
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rx_clock_r <= 1'b0;
    end else begin
      rx_clock_r <= framer_loop_enable_in ? tx_clock_input_in : rx_clock_in;
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_clock_prev_r <= 1'b0;
      tx_idle_r <= 8'h00;
      tx_clock_lost_r <= 1'b0;
    end else begin
      tx_clock_prev_r <= tx_clock_input_in;
      if (tx_clock_input_in != tx_clock_prev_r) begin
        tx_idle_r <= 8'h00;
        tx_clock_lost_r <= 1'b0;
      end else if (tx_idle_r >= elac_pkg::TX_CLOCK_LOSS_CYC) begin
        tx_clock_lost_r <= 1'b1;
      end else begin
        tx_idle_r <= tx_idle_r + 8'h01;
      end
    end
  end

  // glitch-free enough: both sources are sampled levels, switch lands on a clock edge
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_fmt_clock_r <= 1'b0;
    end else if (ctl2_r.tx_clock_source_select) begin
      tx_fmt_clock_r <= rx_clock_in;
    end else if (ctl2_r.tx_clock_loss_mux && tx_clock_lost_r) begin
      tx_fmt_clock_r <= rx_clock_in;
    end else begin
      tx_fmt_clock_r <= tx_clock_input_in;
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rx_serial_r <= 1'b1;
    end else begin
      rx_serial_r <= (ctl2_r.rx_serial_force_control && frame_sync_lost_in) ?
        1'b1 : rx_framer_serial_in;
    end
  end

  elac_zero_run u_zero_run (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .bit_in(line_in),
    .threshold_in(ctl2_r.carrier_loss_alt_criteria ?
      elac_pkg::ZERO_RUN_ALT : elac_pkg::ZERO_RUN_STD),
    .run_out(zero_run),
    .loss_out(carrier_loss)
  );

  // time since frame sync without multiframe sync, saturating
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mf_wait_r <= 32'h00000000;
    end else if (frame_sync_lost_in || crc4_mf_sync_in || !crc4_enable_in) begin
      mf_wait_r <= 32'h00000000;
    end else if (mf_wait_r != 32'hFFFFFFFF) begin
      mf_wait_r <= mf_wait_r + 32'h00000001;
    end
  end

  assign mf_late = mf_wait_r >= 32'(MF_SEARCH_CYC);
  assign mf_giveup = mf_wait_r >= 32'(MF_GIVEUP_CYC);
  assign rx_cond = frame_sync_lost_in | ais_received_in | carrier_loss;

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ais_force_r <= 1'b0;
    end else begin
      ais_force_r <= ctl2_r.auto_all_ones_alarm_enable && rx_cond;
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      remote_alarm_r <= 1'b0;
    end else begin
      remote_alarm_r <= (ctl2_r.auto_remote_alarm_enable &&
        (rx_cond || (crc4_enable_in && mf_late))) || mf_giveup;
    end
  end

  assign update_last = ctl2_r.counter_update_select ?
    32'(UPDATE_FAST_CYC - 1) : 32'(UPDATE_SLOW_CYC - 1);

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      update_cnt_r <= 32'h00000000;
      update_r <= 1'b0;
    end else if (update_cnt_r >= update_last) begin
      update_cnt_r <= 32'h00000000;
      update_r <= 1'b1;
    end else begin
      update_cnt_r <= update_cnt_r + 32'h00000001;
      update_r <= 1'b0;
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      violation_r <= 1'b0;
    end else begin
      violation_r <= ctl2_r.violation_count_type ? code_violation_in : bipolar_violation_in;
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      monitor_r <= 8'h00;
    end else if (tx_fmt_byte_valid_in && tx_fmt_channel_in == ctl3_r.tx_monitor_channel) begin
      monitor_r <= tx_fmt_byte_in;
    end
  end

  assign host_rdata_out = rdata_r;
  assign line_out = line_out_r;
  assign rx_framer_out = rx_framer_r;
  assign rx_clock_out = rx_clock_r;
  assign tx_fmt_clock_out = tx_fmt_clock_r;
  assign tx_clock_lost_out = tx_clock_lost_r;
  assign rx_serial_data_out = rx_serial_r;
  assign rx_carrier_loss_out = carrier_loss;
  assign tx_ais_force_out = ais_force_r;
  assign remote_alarm_indication_out = remote_alarm_r;
  assign counter_update_out = update_r;
  assign violation_count_out = violation_r;
  assign tx_channel_monitor_out = monitor_r;

  default clocking @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);

  sequence s_last_zero_std;
    line_in.en && !line_in.data && zero_run == 12'h0FE && !ctl2_r.carrier_loss_alt_criteria;
  endsequence

  // checker-side stall length; saturates so a dead clock stays flagged
  logic [7:0] idle_chk_r;

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      idle_chk_r <= 8'h00;
    end else if (tx_clock_input_in != tx_clock_prev_r) begin
      idle_chk_r <= 8'h00;
    end else if (idle_chk_r != 8'hFF) begin
      idle_chk_r <= idle_chk_r + 8'h01;
    end
  end

  property p_framer_loop;
    framer_loop_enable_in |=> rx_framer_out == $past(tx_fmt_in);
  endproperty
  a_framer_loop: assert property (p_framer_loop) else $error("framer loop data wrong");

  property p_rx_clock_swap;
    framer_loop_enable_in |=> rx_clock_out == $past(tx_clock_input_in);
  endproperty
  a_rx_clock_swap: assert property (p_rx_clock_swap) else $error("receive clock not swapped");

  property p_update_pulse;
    counter_update_out && !ctl2_r.counter_update_select |=> !counter_update_out [*8];
  endproperty
  a_update_pulse: assert property (p_update_pulse) else $error("update pulse too often");

  property p_violation_type;
    ctl2_r.violation_count_type && code_violation_in |=> violation_count_out;
  endproperty
  a_violation_type: assert property (p_violation_type) else $error("code violation lost");

  property p_serial_force;
    ctl2_r.rx_serial_force_control && frame_sync_lost_in |=> rx_serial_data_out;
  endproperty
  a_serial_force: assert property (p_serial_force) else $error("serial not forced");

  property p_clock_fallback;
    idle_chk_r > elac_pkg::TX_CLOCK_LOSS_CYC |-> tx_clock_lost_out;
  endproperty
  a_clock_fallback: assert property (p_clock_fallback) else $error("clock loss missed");

  property p_clock_source;
    ctl2_r.tx_clock_source_select |=> tx_fmt_clock_out == $past(rx_clock_in);
  endproperty
  a_clock_source: assert property (p_clock_source) else $error("formatter clock wrong");

  property p_carrier_loss;
    s_last_zero_std |=> rx_carrier_loss_out;
  endproperty
  a_carrier_loss: assert property (p_carrier_loss) else $error("carrier loss late");

  property p_auto_ais;
    ctl2_r.auto_all_ones_alarm_enable && rx_cond |=> tx_ais_force_out;
  endproperty
  a_auto_ais: assert property (p_auto_ais) else $error("all-ones alarm missing");

  property p_auto_rai;
    ctl2_r.auto_remote_alarm_enable && rx_cond |=> remote_alarm_indication_out;
  endproperty
  a_auto_rai: assert property (p_auto_rai) else $error("remote alarm missing");

  property p_giveup;
    mf_giveup |=> remote_alarm_indication_out;
  endproperty
  a_giveup: assert property (p_giveup) else $error("constant remote alarm missing");

  property p_remote_loop;
    ctl3_r.remote_loop_enable && !ctl3_r.line_all_ones_force |=> line_out == $past(line_in);
  endproperty
  a_remote_loop: assert property (p_remote_loop) else $error("remote loop data wrong");

  property p_line_ones;
    ctl3_r.line_all_ones_force |=> line_out.data && line_out.en == $past(mclk_tick_in);
  endproperty
  a_line_ones: assert property (p_line_ones) else $error("line all-ones wrong");

  property p_monitor;
    tx_fmt_byte_valid_in && tx_fmt_channel_in == ctl3_r.tx_monitor_channel
      |=> tx_channel_monitor_out == $past(tx_fmt_byte_in);
  endproperty
  a_monitor: assert property (p_monitor) else $error("monitor capture wrong");

  property p_local_loop;
    ctl3_r.local_loop_enable && !framer_loop_enable_in |=> rx_framer_out == $past(line_out);
  endproperty
  a_local_loop: assert property (p_local_loop) else $error("local loop data wrong");

  property p_alarm_release;
    !rx_cond |=> !tx_ais_force_out;
  endproperty
  a_alarm_release: assert property (p_alarm_release) else $error("alarm not released");

endmodule

// ===== elac_pkg.sv
/*
  Shared constants and carrier types for the E1 loopback, alarm and clock control block.
  Assumes a single 25 MHz system clock; all timing counts are derived from CLK_PERIOD_NS.
*/
package elac_pkg;

  // register map
  localparam logic [7:0] LINE_ALARM_CLOCK_CONTROL_ADDR = 8'h13;
  localparam logic [7:0] LOOPBACK_MONITOR_CONTROL_ADDR = 8'h14;
  localparam logic [7:0] LINE_ALARM_CLOCK_CONTROL_RESET = 8'h00;
  localparam logic [7:0] LOOPBACK_MONITOR_CONTROL_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

  // field positions, line_alarm_clock_control
  localparam int CTL2_COUNTER_UPDATE_SELECT_BIT = 7;
  localparam int CTL2_VIOLATION_COUNT_TYPE_BIT = 6;
  localparam int CTL2_AUTO_ALL_ONES_BIT = 5;
  localparam int CTL2_AUTO_REMOTE_ALARM_BIT = 4;
  localparam int CTL2_RX_SERIAL_FORCE_BIT = 3;
  localparam int CTL2_TX_CLOCK_LOSS_MUX_BIT = 2;
  localparam int CTL2_CARRIER_LOSS_ALT_BIT = 1;
  localparam int CTL2_TX_CLOCK_SOURCE_BIT = 0;

  // field positions, loopback_monitor_control
  localparam int CTL3_REMOTE_LOOP_BIT = 7;
  localparam int CTL3_LOCAL_LOOP_BIT = 6;
  localparam int CTL3_LINE_ALL_ONES_BIT = 5;
  localparam int CTL3_TX_MONITOR_MSB = 4;
  localparam int CTL3_TX_MONITOR_LSB = 0;

  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int UPDATE_SLOW_NS = 1000000000;
  localparam int UPDATE_FAST_NS = 62500000;
  localparam int MF_SEARCH_NS = 128000000;
  localparam int MF_GIVEUP_NS = 400000000;
  localparam int TX_CLOCK_LOSS_NS = 2000;
  localparam int UPDATE_SLOW_CYC = UPDATE_SLOW_NS / CLK_PERIOD_NS;
  localparam int UPDATE_FAST_CYC = UPDATE_FAST_NS / CLK_PERIOD_NS;
  localparam int MF_SEARCH_CYC = (MF_SEARCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MF_GIVEUP_CYC = (MF_GIVEUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] TX_CLOCK_LOSS_CYC =
    8'((TX_CLOCK_LOSS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // carrier loss zero-run thresholds
  localparam int ZERO_RUN_W = 12;
  localparam logic [11:0] ZERO_RUN_STD = 12'h0FF;
  localparam logic [11:0] ZERO_RUN_ALT = 12'h800;

  typedef struct packed {
    logic counter_update_select;
    logic violation_count_type;
    logic auto_all_ones_alarm_enable;
    logic auto_remote_alarm_enable;
    logic rx_serial_force_control;
    logic tx_clock_loss_mux;
    logic carrier_loss_alt_criteria;
    logic tx_clock_source_select;
  } elac_ctl2_t;

  typedef struct packed {
    logic remote_loop_enable;
    logic local_loop_enable;
    logic line_all_ones_force;
    logic [4:0] tx_monitor_channel;
  } elac_ctl3_t;

  // one serial bit with its bit-time strobe
  typedef struct packed {
    logic data;
    logic en;
  } elac_bit_t;

endpackage

// ===== elac_zero_run.sv
/*
  Consecutive-zero run counter for receive carrier loss detection.
  Assumes the bit strobe marks one received line bit per pulse.
*/
`timescale 1ns/100ps
module elac_zero_run (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire elac_pkg::elac_bit_t bit_in,
  input wire logic [11:0] threshold_in,
  output logic [11:0] run_out,
  output logic loss_out
);

  logic [11:0] run_r;
  logic loss_r;

  // saturating count, so a dead line never wraps back to clear
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      run_r <= 12'h000;
    end else if (bit_in.en) begin
      if (bit_in.data) begin
        run_r <= 12'h000;
      end else if (run_r != 12'hFFF) begin
        run_r <= run_r + 12'h001;
      end
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      loss_r <= 1'b0;
    end else if (bit_in.en) begin
      if (bit_in.data) begin
        loss_r <= 1'b0;
      end else if ((run_r + 12'h001) >= threshold_in) begin
        loss_r <= 1'b1;
      end
    end
  end

  assign run_out = run_r;
  assign loss_out = loss_r;

endmodule

// ===== elac_line_model.sv
/*
  far-end line equipment model: one received line bit per strobe.
  assumes clock and reset shared with the control block.
*/
`timescale 1ns/100ps
module elac_line_model (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic [1:0] mode_in,
  input wire logic data_in,
  output elac_pkg::elac_bit_t line_out
);
  logic [1:0] div_r;
  // mode 0 idle, 1 zeros, 2 bench data; strobe every fourth cycle
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      div_r <= 2'h0;
      line_out <= '0;
    end else begin
      div_r <= div_r + 2'h1;
      line_out.en <= (mode_in != 2'h0) && (div_r == 2'h3);
      if (mode_in == 2'h0) begin
        // idle line toggles so no stale level looks valid
        line_out.data <= ~line_out.data;
      end else begin
        line_out.data <= (mode_in == 2'h2) ? data_in : 1'h0;
      end
    end
  end
endmodule

// ===== tb.sv
/*
  self-checking bench for the E1 loopback, alarm and clock control block.
  assumes the line model and the package; timers shortened by parameters.
*/
`timescale 1ns/100ps
module tb;
  localparam int SLOW = 40;
  localparam int FAST = 20;
  logic clock_in = 1'h0;
  logic reset_n_in = 1'h0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic host_wr = 1'h0;
  logic host_rd = 1'h0;
  logic floop = 1'h0;
  logic tie0 = 1'h0;
  logic crc4 = 1'h0;
  logic txclk = 1'h0;
  logic rxclk = 1'h0;
  logic fsl = 1'h0;
  logic bpv = 1'h0;
  logic cv = 1'h0;
  logic [4:0] chan = 5'h00;
  logic [7:0] byte_d = 8'h00;
  logic bval = 1'h0;
  elac_pkg::elac_bit_t fmt = '0;
  elac_pkg::elac_bit_t line_in;
  elac_pkg::elac_bit_t line_out;
  elac_pkg::elac_bit_t rxf;
  logic [7:0] rdata;
  logic [7:0] mon_o;
  logic rxclk_o, fclk_o, lost_o, ser_o, cl_o, ais_o, rai_o, upd_o, vc_o;
  logic [1:0] pmode = 2'h0;
  logic pdata = 1'h1;
  logic rnd_on = 1'h0;
  logic watch = 1'h0;
  logic rd_seen = 1'h0;
  logic [7:0] v;
  logic [7:0] q_rd[$];
  logic q_line[$];
  logic q_fl[$];
  integer seed = 32'hBDCBC45A;
  int mismatches = 0;
  int n_tests = 0;
  int i;

  elac_line_model u_elac_line_model (.clock_in(clock_in), .reset_n_in(reset_n_in),
    .mode_in(pmode), .data_in(pdata), .line_out(line_in));

  elac_control #(.UPDATE_SLOW_CYC(SLOW), .UPDATE_FAST_CYC(FAST), .MF_SEARCH_CYC(30),
    .MF_GIVEUP_CYC(60)) u_elac_control (
    .clock_in(clock_in), .reset_n_in(reset_n_in), .host_addr_in(addr),
    .host_wr_in(host_wr), .host_rd_in(host_rd), .host_wdata_in(wdata),
    .host_rdata_out(rdata), .framer_loop_enable_in(floop), .crc4_enable_in(crc4),
    .tx_fmt_in(fmt), .line_in(line_in), .mclk_tick_in(fmt.en),
    .tx_clock_input_in(txclk), .rx_clock_in(rxclk), .rx_framer_serial_in(tie0),
    .frame_sync_lost_in(fsl), .ais_received_in(tie0), .crc4_mf_sync_in(tie0),
    .bipolar_violation_in(bpv), .code_violation_in(cv), .tx_fmt_channel_in(chan),
    .tx_fmt_byte_in(byte_d), .tx_fmt_byte_valid_in(bval), .line_out(line_out),
    .rx_framer_out(rxf), .rx_clock_out(rxclk_o), .tx_fmt_clock_out(fclk_o),
    .tx_clock_lost_out(lost_o), .rx_serial_data_out(ser_o),
    .rx_carrier_loss_out(cl_o), .tx_ais_force_out(ais_o),
    .remote_alarm_indication_out(rai_o), .counter_update_out(upd_o),
    .violation_count_out(vc_o), .tx_channel_monitor_out(mon_o));

  always #20 clock_in = ~clock_in;

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    n_tests++;
    if (e !== g) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chkb(string n, logic e, logic g);
    chk(n, {7'h00, e}, {7'h00, g});
  endtask

  task automatic tmo;
    mismatches++;
    $display("[ERR] wait expected done seen timeout");
    wrap_up();
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask

  task automatic wreg(logic [7:0] a, logic [7:0] d);
    addr = a;
    wdata = d;
    host_wr = 1'h1;
    cyc(1);
    host_wr = 1'h0;
    cyc(1);
  endtask

  task automatic rreg(logic [7:0] a, logic [7:0] e);
    addr = a;
    host_rd = 1'h1;
    q_rd.push_back(e);
    cyc(1);
    host_rd = 1'h0;
    cyc(1);
  endtask

  task automatic strobes(int n);
    int k;
    int t;
    k = 0;
    t = 0;
    while (k < n && t < 8 * n + 8) begin
      @(posedge clock_in);
      if (line_in.en) k++;
      t++;
    end
    #1;
    if (k < n) tmo();
  endtask

  task automatic gap(int e);
    int n;
    n = 0;
    while (upd_o !== 1'h1 && n < 100) begin
      cyc(1);
      n++;
    end
    if (n >= 100) tmo();
    cyc(1);
    n = 0;
    while (upd_o !== 1'h1 && n < 100) begin
      cyc(1);
      n++;
    end
    if (n >= 100) tmo();
    chk("update_gap", 8'(e), 8'(n + 1));
  endtask

  // random stimulus for formatter stream and far-end data
  always @(posedge clock_in) begin
    #1;
    pdata = rnd_on ? 1'($random(seed)) : 1'h1;
    fmt.en = ~fmt.en;
    fmt.data = 1'($random(seed));
  end

  // watcher: pop oldest note when a result shows
  always @(posedge clock_in) begin
    if (rd_seen && q_rd.size() > 0) chk("rdata", q_rd.pop_front(), rdata);
    rd_seen <= host_rd;
    if (watch && line_out.en && q_line.size() > 0) chkb("line_out", q_line.pop_front(), line_out.data);
    if (watch && line_in.en) q_line.push_back(line_in.data);
    if (floop && rxf.en && q_fl.size() > 0) chkb("rx_framer", q_fl.pop_front(), rxf.data);
    if (floop && fmt.en) q_fl.push_back(fmt.data);
  end

  initial begin
    cyc(5);
    reset_n_in = 1'h1;
    cyc(1);
    rreg(8'h13, elac_pkg::LINE_ALARM_CLOCK_CONTROL_RESET);
    rreg(8'h14, elac_pkg::LOOPBACK_MONITOR_CONTROL_RESET);
    v = 8'($random(seed));
    wreg(8'h13, v);
    wreg(8'h15, 8'hFF);
    rreg(8'h13, v);
    rreg(8'h15, 8'h00);
    wreg(8'h13, 8'h00);
    $display("test registers done");
    wreg(8'h14, 8'h80);
    pmode = 2'h2;
    rnd_on = 1'h1;
    cyc(2);
    watch = 1'h1;
    strobes(20);
    watch = 1'h0;
    rnd_on = 1'h0;
    wreg(8'h14, 8'h00);
    $display("test remote loop done");
    for (i = 0; i < 2; i++) begin
      wreg(8'h13, {6'h00, i[0], 1'h0});
      pmode = 2'h2;
      strobes(2);
      pmode = 2'h1;
      strobes(i ? int'(elac_pkg::ZERO_RUN_ALT) - 1 : int'(elac_pkg::ZERO_RUN_STD) - 1);
      cyc(1);
      chkb("carrier_loss", 1'h0, cl_o);
      strobes(1);
      cyc(1);
      chkb("carrier_loss", 1'h1, cl_o);
    end
    pmode = 2'h2;
    strobes(1);
    cyc(1);
    chkb("carrier_loss", 1'h0, cl_o);
    $display("test carrier loss done");
    wreg(8'h13, 8'h00);
    gap(SLOW);
    wreg(8'h13, 8'h80);
    gap(FAST);
    for (i = 0; i < 2; i++) begin
      wreg(8'h13, {1'h0, i[0], 6'h00});
      bpv = 1'h1;
      cyc(1);
      bpv = 1'h0;
      chkb("violation", !i[0], vc_o);
      cv = 1'h1;
      cyc(1);
      cv = 1'h0;
      chkb("violation", i[0], vc_o);
    end
    $display("test counters done");
    wreg(8'h13, 8'h08);
    fsl = 1'h1;
    cyc(2);
    chkb("rx_serial", 1'h1, ser_o);
    wreg(8'h13, 8'h20);
    cyc(2);
    chkb("rx_serial", 1'h0, ser_o);
    chkb("ais_force", 1'h1, ais_o);
    fsl = 1'h0;
    cyc(2);
    chkb("ais_force", 1'h0, ais_o);
    wreg(8'h13, 8'h10);
    fsl = 1'h1;
    cyc(2);
    chkb("remote_alarm", 1'h1, rai_o);
    fsl = 1'h0;
    cyc(2);
    chkb("remote_alarm", 1'h0, rai_o);
    crc4 = 1'h1;
    cyc(20);
    chkb("remote_alarm", 1'h0, rai_o);
    cyc(20);
    chkb("remote_alarm", 1'h1, rai_o);
    wreg(8'h13, 8'h00);
    cyc(2);
    chkb("remote_alarm", 1'h0, rai_o);
    cyc(30);
    chkb("remote_alarm", 1'h1, rai_o);
    crc4 = 1'h0;
    $display("test alarms done");
    wreg(8'h13, 8'h01);
    rxclk = 1'h1;
    cyc(2);
    chkb("fmt_clock", 1'h1, fclk_o);
    rxclk = 1'h0;
    txclk = 1'h1;
    cyc(2);
    chkb("fmt_clock", 1'h0, fclk_o);
    floop = 1'h1;
    cyc(2);
    chkb("rx_clock", 1'h1, rxclk_o);
    txclk = 1'h0;
    rxclk = 1'h1;
    cyc(8);
    chkb("rx_clock", 1'h0, rxclk_o);
    floop = 1'h0;
    wreg(8'h13, 8'h04);
    txclk = 1'h1;
    rxclk = 1'h0;
    cyc(40);
    chkb("clock_lost", 1'h0, lost_o);
    chkb("fmt_clock", 1'h1, fclk_o);
    cyc(20);
    chkb("clock_lost", 1'h1, lost_o);
    chkb("fmt_clock", 1'h0, fclk_o);
    $display("test clocks done");
    wreg(8'h14, 8'h05);
    v = 8'($random(seed));
    chan = 5'h05;
    byte_d = v;
    bval = 1'h1;
    cyc(1);
    chan = 5'h06;
    byte_d = ~v;
    cyc(1);
    bval = 1'h0;
    cyc(1);
    chk("monitor", v, mon_o);
    $display("test monitor done");
    pmode = 2'h1;
    wreg(8'h14, 8'h60);
    cyc(2);
    chkb("line_ones", 1'h1, line_out.data);
    chkb("local_loop", 1'h1, rxf.data);
    $display("test local loop done");
    wrap_up();
  end
endmodule
